// ==== hdl/iscb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "iscb_map.svh"
// Contract
// R1: Software sets stop_request at the end of a transfer while the clock line is held low.
// R2: A Stop starts by driving the data line low, and once it reads low the clock line is released.
// R3: When the released clock reads high the bit_rate_counter loads the reload value and runs to zero.
// R4: Data still low after its release and a counter expiry is a Stop collision.
// R5: Clock read low after its release, before the data line is released, is a Stop collision.
// R6: A collision sets collision_irq_flag, returns to Idle, aborts the Stop and frees both lines.
// R7: After a good Stop the stop-detected bit sets, and one counter_period later stop_request clears and port_irq_flag sets.
// R8: One bit_rate_counter times the serial clock in both two-wire and SPI master modes.
// R9: Writing serial_data_buffer starts the bit_rate_counter on its own.
// R10: When the operation ends the counter stops and the clock pin keeps its last level.
// R11: The counter reloads twice per serial clock period, under mode-dependent conditions.
// R12: The serial clock is the system clock over four times reload plus one, two rollovers a period.
// R13: Software never programs reload values zero, one or two for the two-wire bus.
module iscb_top
    import iscb_pkg::*;
#(
    parameter int AW = 8
) (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // AXI4-Lite slave
    input  wire logic [AW-1:0]     s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [AW-1:0]     s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Two-wire bus pins
    input  wire iscb_line_s        line_in,
    output iscb_drive_s            line_drv,
    // SPI master pins
    input  wire logic              spi_sdi,
    output iscb_spi_s              spi_out,
    // Interrupt
    output logic                   irq
);
    function automatic logic is_i2c(input logic [3:0] m);
        return m == `ISCB_MODE_I2C_MST;
    endfunction
    function automatic logic is_spi(input logic [3:0] m);
        return m == `ISCB_MODE_SPI_MST;
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [3:0]  mode_r;
    logic        en_r;
    logic        stop_req_r;
    logic [7:0]  reload_r;
    logic [7:0]  buf_r;
    logic        wcol_r;
    logic        stop_det_r;
    logic [1:0]  flags_r;
    logic [1:0]  mask_r;
    iscb_stop_e  st_r;
    iscb_stop_e  st_nxt;
    logic [8:0]  cnt_r;
    logic        run_r;
    logic [4:0]  halves_r;
    iscb_drive_s drv_r;
    iscb_spi_s   spi_r;
    logic        irq_r;

    // ------------------------------------------------------------------
    // AXI4-Lite slave: one write and one read at a time
    // ------------------------------------------------------------------
    logic          aw_got_r, w_got_r, bvalid_r, rvalid_r;
    logic [AW-1:0] awaddr_r;
    logic [31:0]   wdata_r, rdata_r;
    logic [1:0]    bresp_r, rresp_r;
    wire aw_hs   = s_axi_awvalid & s_axi_awready;
    wire w_hs    = s_axi_wvalid & s_axi_wready;
    wire do_wr   = aw_got_r & w_got_r & ~bvalid_r;
    wire lane0   = s_axi_wstrb[0];
    wire [7:0] waddr = awaddr_r[7:0];
    wire [7:0] wbyte = wdata_r[7:0];
    wire wr_ctrl = do_wr & (waddr == `ISCB_OFF_CTRL);
    wire wr_seq  = do_wr & (waddr == `ISCB_OFF_SEQ);
    wire wr_rld  = do_wr & (waddr == `ISCB_OFF_RELOAD);
    wire wr_buf  = do_wr & (waddr == `ISCB_OFF_BUF);
    wire wr_stat = do_wr & (waddr == `ISCB_OFF_STATUS);
    wire wr_flag = do_wr & (waddr == `ISCB_OFF_FLAGS);
    wire wr_mask = do_wr & (waddr == `ISCB_OFF_ENABLE);
    wire wr_hit  = wr_ctrl | wr_seq | wr_rld | wr_buf | wr_stat | wr_flag | wr_mask;
    logic wstrb_r;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r  <= `ISCB_RESP_OKAY;
            awaddr_r <= '0;
            wdata_r  <= '0;
            wstrb_r  <= 1'b0;
        end else begin
            if (aw_hs) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= lane0;
            end
            if (do_wr) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? `ISCB_RESP_OKAY : `ISCB_RESP_SLVERR;
                aw_got_r <= 1'b0;
                w_got_r  <= 1'b0;
            end else if (bvalid_r & s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end
    assign s_axi_awready = ~aw_got_r & ~bvalid_r;
    assign s_axi_wready  = ~w_got_r & ~bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;

    wire [7:0] raddr = s_axi_araddr[7:0];
    wire [7:0] status_v = {wcol_r, 2'b00, stop_det_r, 2'b00, (st_r != STP_IDLE) | run_r, 1'b0};
    logic [7:0] rbyte;
    logic       rhit;
    always_comb begin
        rhit = 1'b1;
        case (raddr)
            `ISCB_OFF_CTRL:   rbyte = {2'b00, en_r, 1'b0, mode_r};
            `ISCB_OFF_SEQ:    rbyte = {5'h00, stop_req_r, 2'b00};
            `ISCB_OFF_RELOAD: rbyte = reload_r;
            `ISCB_OFF_BUF:    rbyte = buf_r;
            `ISCB_OFF_STATUS: rbyte = status_v;
            `ISCB_OFF_FLAGS:  rbyte = {6'h00, flags_r};
            `ISCB_OFF_ENABLE: rbyte = {6'h00, mask_r};
            default: begin
                rbyte = `ISCB_RST_BYTE;
                rhit  = 1'b0;
            end
        endcase
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= `ISCB_RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r  <= {24'h000000, rbyte};
            rresp_r  <= rhit ? `ISCB_RESP_OKAY : `ISCB_RESP_SLVERR;
        end else if (rvalid_r & s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // ------------------------------------------------------------------
    // Bit rate counter, shared by both master modes
    // ------------------------------------------------------------------
    // Loading {reload,1} gives 2*(reload+1) cycles a half period, so a
    // full period is 4*(reload+1) system clocks.
    wire i2c_on    = en_r & is_i2c(mode_r);
    wire spi_on    = en_r & is_spi(mode_r);
    wire stop_busy = st_r != STP_IDLE;
    wire spi_busy  = halves_r != 5'h00;
    wire buf_ok    = wr_buf & wstrb_r & ~stop_busy & ~spi_busy;
    wire brg_done  = run_r & (cnt_r == 9'h000);
    wire spi_load  = spi_busy & brg_done & (halves_r != 5'h01);
    logic stp_load;
    wire brg_load  = buf_ok | stp_load | spi_load;                         // [R8] [R9] [R11]
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end else if (brg_load) begin
            cnt_r <= {reload_r, 1'b1};                                     // [R12]
            run_r <= 1'b1;
        end else if (brg_done) begin
            run_r <= 1'b0;                                                 // [R10]
        end else if (run_r) begin
            cnt_r <= cnt_r - 9'h001;
        end
    end

    // ------------------------------------------------------------------
    // Stop sequence with collision checks
    // ------------------------------------------------------------------
    logic coll, stop_ok, stop_end;
    always_comb begin
        st_nxt   = st_r;
        stp_load = 1'b0;
        coll     = 1'b0;
        stop_ok  = 1'b0;
        stop_end = 1'b0;
        case (st_r)
            STP_IDLE:     if (i2c_on & stop_req_r) st_nxt = STP_SDA_LOW;   // [R1]
            STP_SDA_LOW:  if (!line_in.sda) st_nxt = STP_SCL_REL;          // [R2]
            STP_SCL_REL: begin
                if (line_in.scl) begin
                    stp_load = 1'b1;                                       // [R3]
                    st_nxt   = STP_SCL_HIGH;
                end
            end
            STP_SCL_HIGH: begin
                if (!line_in.scl) begin
                    coll = 1'b1;                                           // [R5]
                end else if (brg_done) begin
                    stp_load = 1'b1;
                    st_nxt   = STP_SDA_REL;
                end
            end
            STP_SDA_REL: begin
                if (brg_done & !line_in.sda) begin
                    coll = 1'b1;                                           // [R4]
                end else if (!line_in.scl & !line_in.sda) begin
                    coll = 1'b1;                                           // [R5]
                end else if (brg_done) begin
                    stop_ok  = 1'b1;                                       // [R7]
                    stp_load = 1'b1;
                    st_nxt   = STP_FINAL;
                end
            end
            STP_FINAL: begin
                if (brg_done) begin
                    stop_end = 1'b1;                                       // [R7]
                    st_nxt   = STP_IDLE;
                end
            end
            default: st_nxt = STP_IDLE;
        endcase
        if (coll) st_nxt = STP_IDLE;                                       // [R6]
    end

    // Lines: SCL is held low on entry, as it is after the ninth clock
    wire sda_oe_nxt = (st_nxt == STP_SDA_LOW) | (st_nxt == STP_SCL_REL)
                    | (st_nxt == STP_SCL_HIGH);
    wire scl_oe_nxt = st_nxt == STP_SDA_LOW;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r  <= STP_IDLE;
            drv_r <= '0;
        end else begin
            st_r         <= st_nxt;
            drv_r.sda_oe <= sda_oe_nxt;                                    // [R2] [R6]
            drv_r.scl_oe <= scl_oe_nxt;
            drv_r.sda_o  <= 1'b0;
            drv_r.scl_o  <= 1'b0;
        end
    end
    assign line_drv = drv_r;

    // ------------------------------------------------------------------
    // SPI master: 16 half periods per byte, clock idles where it stopped
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            halves_r <= '0;
            spi_r    <= '0;
            buf_r    <= '0;
        end else if (buf_ok) begin
            buf_r    <= wbyte;
            halves_r <= spi_on ? `ISCB_SPI_HALVES : 5'h00;
            spi_r.sdo <= wbyte[7];
        end else if (spi_busy & brg_done) begin
            halves_r  <= halves_r - 5'h01;
            spi_r.sck <= ~spi_r.sck;                                       // [R11]
            if (!spi_r.sck) begin
                buf_r <= {buf_r[6:0], spi_sdi};
            end else begin
                spi_r.sdo <= buf_r[7];
            end
        end
    end
    assign spi_out = spi_r;

    // ------------------------------------------------------------------
    // Control, status, interrupt flags (set wins over clear, except stop_req_r, where the Stop/collision clear wins)
    // ------------------------------------------------------------------
    wire       spi_end = spi_busy & brg_done & (halves_r == 5'h01);
    wire [1:0] set_fl  = {coll, stop_end | spi_end};
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mode_r     <= `ISCB_RST_MODE;
            en_r       <= 1'b0;
            stop_req_r <= 1'b0;
            reload_r   <= `ISCB_RST_BYTE;
            wcol_r     <= 1'b0;
            stop_det_r <= 1'b0;
            flags_r    <= '0;
            mask_r     <= '0;
            irq_r      <= 1'b0;
        end else begin
            if (wr_ctrl & wstrb_r) begin
                mode_r <= wbyte[3:0];
                en_r   <= wbyte[`ISCB_CTRL_EN_BIT];
            end
            if (wr_rld & wstrb_r) reload_r <= wbyte;
            if (wr_mask & wstrb_r) mask_r <= wbyte[1:0];
            if (stop_end | coll) begin
                stop_req_r <= 1'b0;                                        // [R6] [R7]
            end else if (wr_seq & wstrb_r & wbyte[`ISCB_SEQ_STOP_BIT]) begin
                stop_req_r <= 1'b1;
            end
            if (stop_ok) begin
                stop_det_r <= 1'b1;                                        // [R7]
            end else if (wr_seq & wstrb_r & wbyte[`ISCB_SEQ_STOP_BIT]) begin
                stop_det_r <= 1'b0;
            end
            if (wr_buf & wstrb_r & (stop_busy | spi_busy)) begin
                wcol_r <= 1'b1;
            end else if (wr_stat & wstrb_r & wbyte[`ISCB_ST_WCOL_BIT]) begin
                wcol_r <= 1'b0;
            end
            flags_r <= set_fl | (flags_r & ~((wr_flag & wstrb_r) ? wbyte[1:0] : 2'b00));
            irq_r   <= |(flags_r & mask_r);
        end
    end
    assign irq = irq_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_stop_starts_low: assert property (st_r == STP_IDLE && st_nxt == STP_SDA_LOW |=> drv_r.sda_oe && drv_r.scl_oe) else $error("stop did not drive data low"); // [R2]
    a_scl_release: assert property (st_r == STP_SDA_LOW && !line_in.sda |=> !drv_r.scl_oe) else $error("clock not released after data low"); // [R2]
    a_brg_loads: assert property (st_r == STP_SCL_REL && line_in.scl |=> run_r && cnt_r == {reload_r, 1'b1}) else $error("counter not loaded at clock high"); // [R3]
    a_case1_coll: assert property (st_r == STP_SDA_REL && brg_done && !line_in.sda |=> flags_r[1]) else $error("data-low collision missed"); // [R4]
    a_case2_coll: assert property (st_r == STP_SCL_HIGH && !line_in.scl |=> flags_r[1] && st_r == STP_IDLE) else $error("clock-low collision missed"); // [R5]
    a_coll_frees: assert property (coll |=> !drv_r.sda_oe && !drv_r.scl_oe && !stop_req_r) else $error("collision left lines driven"); // [R6]
    a_stop_finish: assert property (stop_ok |=> stop_det_r && stop_req_r ##[1:600] !stop_req_r && flags_r[0]) else $error("stop did not finish"); // [R7]
    a_buf_starts: assert property (buf_ok |=> run_r) else $error("buffer write did not start counter"); // [R9]
    a_brg_stops: assert property (brg_done && !brg_load |=> !run_r ##1 $stable(spi_r.sck)) else $error("counter kept running"); // [R10]
    a_half_period: assert property (brg_load |=> run_r [*2] ##0 cnt_r == $past(cnt_r) - 9'h001) else $error("counter not counting down"); // [R8] [R12]
    a_spi_toggle: assert property (spi_busy && brg_done |=> spi_r.sck != $past(spi_r.sck)) else $error("sck did not toggle at rollover"); // [R11]
    c_stop_ok: cover property (stop_end);
    c_collision: cover property (coll);
    c_spi_byte: cover property (spi_end);
endmodule
`default_nettype wire

// ==== hdl/iscb_map.svh ====
`ifndef ISCB_MAP_SVH
`define ISCB_MAP_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ISCB_OFF_CTRL    8'h00
`define ISCB_OFF_SEQ     8'h04
`define ISCB_OFF_RELOAD  8'h08
`define ISCB_OFF_BUF     8'h0c
`define ISCB_OFF_STATUS  8'h10
`define ISCB_OFF_FLAGS   8'h14
`define ISCB_OFF_ENABLE  8'h18
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ISCB_CTRL_EN_BIT   5
`define ISCB_SEQ_STOP_BIT  2
`define ISCB_ST_WCOL_BIT   7
`define ISCB_ST_STOP_BIT   4
`define ISCB_ST_BUSY_BIT   1
`define ISCB_FL_PORT_BIT   0
`define ISCB_FL_COLL_BIT   1
// ----------------------------------------------------------------------
// Mode codes and reset values
// ----------------------------------------------------------------------
`define ISCB_MODE_I2C_MST  4'h8
`define ISCB_MODE_SPI_MST  4'ha
`define ISCB_RST_BYTE      8'h00
`define ISCB_RST_MODE      4'h0
`define ISCB_SPI_HALVES    5'h10
`define ISCB_RESP_OKAY     2'h0
`define ISCB_RESP_SLVERR   2'h2
`endif

// ==== hdl/iscb_pkg.sv ====
package iscb_pkg;
    // Open-drain pin pair as seen from the pads
    typedef struct packed {
        logic scl;
        logic sda;
    } iscb_line_s;
    typedef struct packed {
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } iscb_drive_s;
    typedef struct packed {
        logic sck;
        logic sdo;
    } iscb_spi_s;
    typedef enum logic [2:0] {
        STP_IDLE,
        STP_SDA_LOW,
        STP_SCL_REL,
        STP_SCL_HIGH,
        STP_SDA_REL,
        STP_FINAL
    } iscb_stop_e;
endpackage

// ==== tb/iscb_bus_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module iscb_bus_model
    import iscb_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // Device pins
    input  wire iscb_drive_s line_drv,
    output var iscb_line_s   line_in,
    // Other parties on the bus
    input  wire logic [7:0]  stretch_len,
    input  wire logic        peer_sda_low,
    input  wire logic        peer_scl_low
);
    // ----------------------------------------------------------------------
    // Slave clock stretching and wired-AND lines
    // ----------------------------------------------------------------------
    logic [7:0] hold_cnt_r;

    // A slave keeps the clock low for stretch_len cycles after the master lets it go
    always_ff @(posedge sys_clk) begin
        if (sys_rst || line_drv.scl_oe) begin
            hold_cnt_r <= stretch_len;
        end else if (hold_cnt_r != 8'h00) begin
            hold_cnt_r <= hold_cnt_r - 8'h01;
        end
    end

    // Pull-ups: a line nobody pulls reads high
    assign line_in.scl = ~(line_drv.scl_oe | peer_scl_low | (hold_cnt_r != 8'h00));
    assign line_in.sda = ~(line_drv.sda_oe | peer_sda_low);
endmodule
`default_nettype wire

// ==== tb/iscb_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "iscb_map.svh"
module iscb_top_tb
    import iscb_pkg::*;
;
    localparam int RLD = 3;
    localparam int H   = 2 * (RLD + 1);
    logic        sys_clk  = 1'b0;
    logic        sys_rst  = 1'b1;
    logic [7:0]  awaddr   = 8'h00;
    logic        awvalid  = 1'b0;
    logic [31:0] wdata    = 32'h0;
    logic        wvalid   = 1'b0;
    logic        bready   = 1'b0;
    logic [7:0]  araddr   = 8'h00;
    logic        arvalid  = 1'b0;
    logic        rready   = 1'b0;
    logic        sdi_r    = 1'b0;
    logic [7:0]  stretch  = 8'h00;
    logic        jam_sda  = 1'b0;
    logic        jam_scl  = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    iscb_line_s  line_in;
    iscb_drive_s line_drv;
    iscb_spi_s   spi_out;
    int          n_errors    = 0;
    int          comparisons = 0;

    always #5 sys_clk = ~sys_clk;
    // SPI loopback, one clock late: data out is steady long before the sampling toggle
    always @(posedge sys_clk) sdi_r <= spi_out.sdo;

    iscb_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .line_in(line_in), .line_drv(line_drv),
        .spi_sdi(sdi_r), .spi_out(spi_out), .irq(irq));
    iscb_bus_model bus (.sys_clk(sys_clk), .sys_rst(sys_rst), .line_drv(line_drv),
        .line_in(line_in), .stretch_len(stretch), .peer_sda_low(jam_sda),
        .peer_scl_low(jam_scl));

    // ----------------------------------------------------------------------
    // Bus cycles and comparison
    // ----------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ha;
        logic hw;
        @(posedge sys_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge sys_clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            @(posedge sys_clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
        end while (awvalid && !ha || wvalid && !hw);
        do @(negedge sys_clk); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge sys_clk);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic h;
        @(posedge sys_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge sys_clk);
            h = arready;
            @(posedge sys_clk);
        end while (h !== 1'b1);
        arvalid <= 1'b0;
        do @(negedge sys_clk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge sys_clk);
        rready <= 1'b0;
    endtask

    function automatic logic cond(input int k);
        case (k)
            0: cond = line_drv.sda_oe;
            1: cond = !line_drv.scl_oe;
            2: cond = !line_drv.sda_oe;
            default: cond = irq;
        endcase
    endfunction

    // Counts cycles until the chosen condition holds; a hang is a mismatch
    task automatic wait_on(input int k, output int n);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (cond(k) !== 1'b1 && n < 3000);
        check("wait bound", 32'(n < 3000), 32'h1);
    endtask

    task automatic stop_seq(input int st, input logic js, input logic jc);
        int t0;
        int t1;
        logic [31:0] d;
        logic [1:0] r;
        stretch <= 8'(st);
        jam_sda <= js;
        axi_wr(`ISCB_OFF_SEQ, 32'h4, r);
        wait_on(0, t0);
        check("clock held at stop start", 32'(line_drv.scl_oe), 32'h1);
        wait_on(1, t0);
        check("data low at clock release", 32'(line_drv.sda_oe), 32'h1);
        if (jc) begin
            repeat (4) @(posedge sys_clk);
            jam_scl <= 1'b1;
        end
        wait_on(2, t1);
        if (!jc) check("release spacing", 32'(t1 >= st + H && t1 <= st + H + 3), 32'h1);
        if (!(js || jc)) begin
            wait_on(3, t1);
            check("stop to irq", 32'(t1 >= 2 * H && t1 <= 2 * H + 4), 32'h1);
            axi_rd(`ISCB_OFF_STATUS, d, r);
            check("stop detected", d & 32'h10, 32'h10);
        end else begin
            repeat (2 * H + 4) @(posedge sys_clk);
            check("lines after collision", 32'({line_drv.scl_oe, line_drv.sda_oe}), 32'h0);
            check("irq after collision", 32'(irq), 32'h1);
        end
        axi_rd(`ISCB_OFF_FLAGS, d, r);
        check("flags after stop", d, (js || jc) ? 32'h2 : 32'h1);
        axi_rd(`ISCB_OFF_SEQ, d, r);
        check("stop request cleared", d, 32'h0);
        jam_sda <= 1'b0;
        jam_scl <= 1'b0;
        axi_wr(`ISCB_OFF_FLAGS, 32'h3, r);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------------
    // Test sequence
    // ----------------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic last;
        logic [7:0] got;
        int since;
        int tog;
        int bad;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            axi_rd(8'(a * 4), d, r);
            check("reset value", d, 32'h0);
            check("read response", 32'(r), (a < 7) ? 32'h0 : 32'h2);
        end
        axi_wr(8'h1c, 32'hff, r);
        check("unmapped write response", 32'(r), 32'h2);
        axi_wr(`ISCB_OFF_CTRL, 32'h2a, r);
        axi_wr(`ISCB_OFF_RELOAD, 32'(RLD), r);
        axi_wr(`ISCB_OFF_ENABLE, 32'h1, r);
        axi_wr(`ISCB_OFF_BUF, 32'ha5, r);
        // A second write while the byte is shifting must be refused
        axi_wr(`ISCB_OFF_BUF, 32'h00, r);
        last = spi_out.sck;
        {since, tog, bad, got} = '0;
        while (irq !== 1'b1 && since < 3000) begin
            @(negedge sys_clk);
            since++;
            if (spi_out.sck !== last) begin
                if (tog > 0 && since != H) bad++;
                if (spi_out.sck) got = {got[6:0], spi_out.sdo};
                tog++;
                since = 0;
                last = spi_out.sck;
            end
        end
        check("clock toggles", 32'(tog), 32'd16);
        check("half period length", 32'(bad), 32'h0);
        check("shifted byte", 32'(got), 32'ha5);
        // Counter stopped: the clock pin must not move any more
        repeat (3 * H) begin
            @(negedge sys_clk);
            if (spi_out.sck !== last) tog++;
        end
        check("clock held after byte", 32'(tog), 32'd16);
        axi_rd(`ISCB_OFF_BUF, d, r);
        check("loopback byte", d, 32'ha5);
        axi_rd(`ISCB_OFF_STATUS, d, r);
        check("write collision set", d, 32'h80);
        axi_wr(`ISCB_OFF_STATUS, 32'h80, r);
        axi_rd(`ISCB_OFF_STATUS, d, r);
        check("write collision cleared", d, 32'h0);
        axi_wr(`ISCB_OFF_ENABLE, 32'h0, r);
        repeat (2) @(posedge sys_clk);
        check("irq masked", 32'(irq), 32'h0);
        axi_rd(`ISCB_OFF_FLAGS, d, r);
        check("port flag sticky", d, 32'h1);
        axi_wr(`ISCB_OFF_ENABLE, 32'h3, r);
        repeat (2) @(posedge sys_clk);
        check("irq unmasked", 32'(irq), 32'h1);
        axi_wr(`ISCB_OFF_FLAGS, 32'h1, r);
        repeat (2) @(posedge sys_clk);
        check("irq after clear", 32'(irq), 32'h0);
        axi_wr(`ISCB_OFF_CTRL, 32'h28, r);
        stop_seq(0, 1'b0, 1'b0);
        stop_seq(20, 1'b0, 1'b0);
        stop_seq(0, 1'b1, 1'b0);
        stop_seq(0, 1'b0, 1'b1);
        stop_seq(0, 1'b0, 1'b0);
        give_verdict;
    end

    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        give_verdict;
    end
endmodule
`default_nettype wire
